//--- common/embc_map.svh
// Constants for the external memory bus and reset controller
`ifndef EMBC_MAP_SVH
`define EMBC_MAP_SVH
// Overview of operation
// RQ1 - One strobe low per memory transfer
// RQ2 - Memory gives read data before strobe rises
// RQ3 - Write data driven when strobe falls
// RQ4 - Address latch pulse starts each machine cycle
// RQ5 - Memory latches address on latch rising edge
// RQ6 - Low address on muxed port each access
// RQ7 - Direction low on write, high on read
// RQ8 - Reset lows under four clocks ignored
// RQ9 - Latch reset fifth clock, hold eighteen minimum
// RQ10 - Reset holds strobe low, latch toggles
// RQ11 - First fetch after reset at 000C
// RQ12 - System clock shown on output pin
// RQ13 - Interrupt cycle flag high during interrupt
// RQ14 - Instruction end low in last cycle
// RQ15 - Stall input low freezes access cycle
// RQ16 - Stall sampled only after strobe falls
// RQ17 - Upper port nibbles: I/O or address
// RQ18 - Handshake lines follow upper nibble direction
// RQ19 - Address 11..8 or 15..8 from nibbles
// RQ20 - Reset gives address nibbles, extended timing
// RQ21 - Software writes mode register for I/O
// RQ22 - Undriven upper inputs held at valid level
// RQ23 - Muxed port carries address then data
// RQ24 - Stall input synchronised by two stages

// Reset timing, in external clock periods
`define EMBC_FILTER_PERIODS   4
`define EMBC_LATCH_PERIODS    5
`define EMBC_HOLD_PERIODS     18
`define EMBC_FILTER_CYC       (`EMBC_FILTER_PERIODS)
`define EMBC_LATCH_CYC        (`EMBC_LATCH_PERIODS)
`define EMBC_HOLD_CYC         (`EMBC_HOLD_PERIODS)

// Bus timing, in clock cycles, and reset fetch address
`define EMBC_STROBE_CYC       3
`define EMBC_EXT_STROBE_CYC   2
`define EMBC_RESET_VECTOR     16'h000C

// Register offsets
`define EMBC_REG_MODE         4'h0
`define EMBC_REG_OUT          4'h1
`define EMBC_REG_IN           4'h2
`define EMBC_REG_STATUS       4'h3

// Mode register fields
`define EMBC_MODE_LO_LSB      0
`define EMBC_MODE_HI_LSB      2
`define EMBC_MODE_EXT_BIT     4
`define EMBC_MODE_HS_BIT      5
`define EMBC_MODE_RESET       8'h1A
`define EMBC_NIB_IN           2'h0
`define EMBC_NIB_OUT          2'h1
`define EMBC_NIB_ADDR         2'h2

// Status register fields
`define EMBC_ST_BUSY_BIT      0
`define EMBC_ST_BOOT_BIT      1
`define EMBC_ST_INFULL_BIT    2
`define EMBC_ST_DAV_BIT       3
`define EMBC_ST_RST_BIT       4
`endif

//--- common/embc_pkg.sv
// Types for the external memory bus and reset controller
package embc_pkg;
	typedef enum logic [2:0] {
		EMBC_ST_IDLE,
		EMBC_ST_ADDR,
		EMBC_ST_HOLD,
		EMBC_ST_STROBE,
		EMBC_ST_END
	} embc_bus_state_t;

	typedef enum logic [1:0] {
		EMBC_FLT_IDLE,
		EMBC_FLT_DELAY,
		EMBC_FLT_HOLD
	} embc_flt_state_t;
endpackage

//--- verilog/embc_reset_filter.sv
// Reset pin filter and internal reset stretcher
`timescale 1ns/1ps
`default_nettype none
`include "embc_map.svh"
module embc_reset_filter (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic ext_reset_n,
	output logic      int_rst
);
	logic                      pin_meta;
	logic                      pin_sync;
	logic [2:0]                low_cnt;
	logic [2:0]                delay_cnt;
	logic [4:0]                hold_cnt;
	embc_pkg::embc_flt_state_t flt_state;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pin_meta <= 1'b1;
			pin_sync <= 1'b1;
		end else begin
			pin_meta <= ext_reset_n;
			pin_sync <= pin_meta;
		end
	end

	// Consecutive low cycles of the pin
	always_ff @(posedge ref_clk) begin
		if (!rst_n || pin_sync) begin
			low_cnt <= 3'h0;
		end else if (low_cnt != 3'(`EMBC_FILTER_CYC)) begin
			low_cnt <= low_cnt + 3'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			flt_state <= embc_pkg::EMBC_FLT_IDLE;
			delay_cnt <= 3'h0;
			hold_cnt  <= 5'h00;
			int_rst   <= 1'b0;
		end else begin
			case (flt_state)
				embc_pkg::EMBC_FLT_IDLE: begin
					delay_cnt <= 3'h1;
					if (low_cnt == 3'(`EMBC_FILTER_CYC)) begin // RQ8
						flt_state <= embc_pkg::EMBC_FLT_DELAY;
					end
				end
				embc_pkg::EMBC_FLT_DELAY: begin
					delay_cnt <= delay_cnt + 3'h1;
					hold_cnt  <= 5'h00;
					if (delay_cnt == 3'(`EMBC_LATCH_CYC)) begin // RQ9
						int_rst   <= 1'b1;
						flt_state <= embc_pkg::EMBC_FLT_HOLD;
					end
				end
				embc_pkg::EMBC_FLT_HOLD: begin
					if (hold_cnt != 5'(`EMBC_HOLD_CYC)) begin
						hold_cnt <= hold_cnt + 5'h01;
					end
					// Longer of the minimum hold and the pin low time
					if (hold_cnt == 5'(`EMBC_HOLD_CYC) && pin_sync) begin // RQ9
						int_rst   <= 1'b0;
						flt_state <= embc_pkg::EMBC_FLT_IDLE;
					end
				end
				default: begin
					flt_state <= embc_pkg::EMBC_FLT_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

//--- verilog/embc_bus_ctrl.sv
// External memory bus controller with upper address port
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "embc_map.svh"
module embc_bus_ctrl (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        ext_reset_n,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic        req_write,
	input  wire logic [15:0] req_addr,
	input  wire logic [7:0]  req_wdata,
	output logic             resp_valid,
	output logic      [7:0]  resp_rdata,
	output logic             resp_boot,
	input  wire logic        irq_cycle_in,
	input  wire logic        instr_last_in,
	output logic             irq_cycle_flag,
	output logic             instr_end_n,
	output logic             sys_clk_out,
	output logic             mem_strobe_n,
	output logic             addr_latch_pulse_n,
	output logic             read_write,
	input  wire logic        stall_n,
	input  wire logic [7:0]  muxed_bus_in,
	output logic      [7:0]  muxed_bus_out,
	output logic             muxed_bus_oe_n,
	input  wire logic [7:0]  upper_address_port_in,
	output logic      [7:0]  upper_address_port_out,
	output logic      [7:0]  drive_enable_n,
	input  wire logic        ctrl_port_line2,
	output logic             ctrl_port_line5,
	output logic             int_rst
);
	embc_pkg::embc_bus_state_t state;
	embc_pkg::embc_bus_state_t next_state;
	logic        sys_rst;
	logic        stall_meta;
	logic        stall_sync;
	logic [7:0]  bus_meta;
	logic [7:0]  bus_sync;
	logic [7:0]  upper_meta;
	logic [7:0]  upper_sync;
	logic        line2_meta;
	logic        line2_sync;
	logic        line2_prev;
	logic [15:0] cyc_addr;
	logic        cyc_write;
	logic [7:0]  cyc_wdata;
	logic        cyc_boot;
	logic [2:0]  str_cnt;
	logic [2:0]  str_last;
	logic        str_done;
	logic        boot_pending;
	logic        start;
	logic [15:0] start_addr;
	logic [15:0] drive_addr;
	logic [7:0]  mode;
	logic [1:0]  lo_mode;
	logic [1:0]  hi_mode;
	logic        ext_timing;
	logic        hs_active;
	logic        hs_out_dir;
	logic [7:0]  out_data;
	logic [7:0]  in_latch;
	logic        in_full;
	logic        data_avail_pend;
	logic        upper_port_data_avail_n;
	logic        upper_port_hs_ready;
	logic        wr_out;
	logic        rd_in;

	embc_reset_filter u_reset_filter (
		.ref_clk     (ref_clk),
		.rst_n       (rst_n),
		.ext_reset_n (ext_reset_n),
		.int_rst     (int_rst)
	);

	assign sys_rst = !rst_n || int_rst;

	// Pin synchronisers
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			stall_meta <= 1'b1;
			stall_sync <= 1'b1;
			bus_meta   <= 8'h00;
			bus_sync   <= 8'h00;
			upper_meta <= 8'h00;
			upper_sync <= 8'h00;
			line2_meta <= 1'b1;
			line2_sync <= 1'b1;
			line2_prev <= 1'b1;
		end else begin
			stall_meta <= stall_n; // RQ24
			stall_sync <= stall_meta; // RQ24
			bus_meta   <= muxed_bus_in;
			bus_sync   <= bus_meta;
			upper_meta <= upper_address_port_in;
			upper_sync <= upper_meta;
			line2_meta <= ctrl_port_line2;
			line2_sync <= line2_meta;
			line2_prev <= line2_sync;
		end
	end

	assign lo_mode    = mode[`EMBC_MODE_LO_LSB +: 2];
	assign hi_mode    = mode[`EMBC_MODE_HI_LSB +: 2];
	assign ext_timing = mode[`EMBC_MODE_EXT_BIT];
	// Handshake needs both nibbles in the same I/O direction
	assign hs_active  = mode[`EMBC_MODE_HS_BIT] && lo_mode == hi_mode
		&& lo_mode != `EMBC_NIB_ADDR; // RQ18
	assign hs_out_dir = hi_mode == `EMBC_NIB_OUT; // RQ18

	assign req_ready  = state == embc_pkg::EMBC_ST_IDLE && !sys_rst && !boot_pending;
	assign start      = state == embc_pkg::EMBC_ST_IDLE && !sys_rst
		&& (boot_pending || req_valid);
	assign start_addr = boot_pending ? `EMBC_RESET_VECTOR : req_addr; // RQ11
	assign drive_addr = start ? start_addr : cyc_addr;
	assign str_last   = ext_timing ? 3'(`EMBC_STROBE_CYC + `EMBC_EXT_STROBE_CYC - 1)
		: 3'(`EMBC_STROBE_CYC - 1);
	// Stall copy at this point was taken while the strobe was low
	assign str_done   = str_cnt == str_last && stall_sync; // RQ15 RQ16

	always_comb begin
		next_state = state;
		case (state)
			embc_pkg::EMBC_ST_IDLE: begin
				if (start) begin
					next_state = embc_pkg::EMBC_ST_ADDR;
				end
			end
			embc_pkg::EMBC_ST_ADDR: begin
				next_state = embc_pkg::EMBC_ST_HOLD;
			end
			embc_pkg::EMBC_ST_HOLD: begin
				next_state = embc_pkg::EMBC_ST_STROBE;
			end
			embc_pkg::EMBC_ST_STROBE: begin
				if (str_done) begin
					next_state = embc_pkg::EMBC_ST_END;
				end
			end
			embc_pkg::EMBC_ST_END: begin
				next_state = embc_pkg::EMBC_ST_IDLE;
			end
			default: begin
				next_state = embc_pkg::EMBC_ST_IDLE;
			end
		endcase
		if (sys_rst) begin
			next_state = embc_pkg::EMBC_ST_IDLE;
		end
	end

	always_ff @(posedge ref_clk) begin
		state <= next_state;
	end

	// Cycle capture and strobe counting
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cyc_addr     <= 16'h0000;
			cyc_write    <= 1'b0;
			cyc_wdata    <= 8'h00;
			cyc_boot     <= 1'b0;
			boot_pending <= 1'b1; // RQ11
			str_cnt      <= 3'h0;
		end else begin
			if (start) begin
				cyc_addr     <= start_addr;
				cyc_write    <= boot_pending ? 1'b0 : req_write;
				cyc_wdata    <= req_wdata;
				cyc_boot     <= boot_pending;
				boot_pending <= 1'b0;
			end
			if (state == embc_pkg::EMBC_ST_HOLD) begin
				str_cnt <= 3'h0;
			end else if (state == embc_pkg::EMBC_ST_STROBE && str_cnt != str_last) begin
				str_cnt <= str_cnt + 3'h1;
			end
		end
	end

	// Core response
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			resp_valid <= 1'b0;
			resp_rdata <= 8'h00;
			resp_boot  <= 1'b0;
		end else begin
			resp_valid <= state == embc_pkg::EMBC_ST_STROBE && str_done;
			if (state == embc_pkg::EMBC_ST_STROBE && str_done) begin
				resp_boot <= cyc_boot;
				if (!cyc_write) begin
					resp_rdata <= bus_sync; // RQ2
				end
			end
		end
	end

	// Bus strobes; during internal reset the strobe stays low and the latch toggles
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			addr_latch_pulse_n <= 1'b1;
			mem_strobe_n       <= 1'b1;
			read_write         <= 1'b1;
		end else if (int_rst) begin
			addr_latch_pulse_n <= !addr_latch_pulse_n; // RQ10
			mem_strobe_n       <= 1'b0; // RQ10
			read_write         <= 1'b1;
		end else begin
			addr_latch_pulse_n <= next_state != embc_pkg::EMBC_ST_ADDR; // RQ4 RQ5
			mem_strobe_n       <= next_state != embc_pkg::EMBC_ST_STROBE; // RQ1
			if (start) begin
				read_write <= boot_pending || !req_write; // RQ7
			end else if (next_state == embc_pkg::EMBC_ST_IDLE) begin
				read_write <= 1'b1;
			end
		end
	end

	// Multiplexed port: address first, then write data
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			muxed_bus_out  <= 8'h00;
			muxed_bus_oe_n <= 1'b1;
		end else if (next_state == embc_pkg::EMBC_ST_ADDR
			|| next_state == embc_pkg::EMBC_ST_HOLD) begin
			muxed_bus_out  <= drive_addr[7:0]; // RQ6 RQ23
			muxed_bus_oe_n <= 1'b0;
		end else if ((next_state == embc_pkg::EMBC_ST_STROBE
			|| next_state == embc_pkg::EMBC_ST_END) && cyc_write) begin
			muxed_bus_out  <= cyc_wdata; // RQ3 RQ23
			muxed_bus_oe_n <= 1'b0;
		end else begin
			muxed_bus_oe_n <= 1'b1;
		end
	end

	assign wr_out = reg_wr && reg_addr == `EMBC_REG_OUT;
	assign rd_in  = reg_rd && reg_addr == `EMBC_REG_IN;

	// Mode and output data registers
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			mode     <= `EMBC_MODE_RESET; // RQ20
			out_data <= 8'h00;
		end else if (reg_wr) begin
			if (reg_addr == `EMBC_REG_MODE) begin
				mode <= reg_wdata; // RQ17 RQ21
			end else if (reg_addr == `EMBC_REG_OUT) begin
				out_data <= reg_wdata;
			end
		end
	end

	// Handshake flags; a set in the same cycle beats the clear
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			data_avail_pend <= 1'b0;
			in_full         <= 1'b0;
			in_latch        <= 8'h00;
		end else begin
			if (!hs_active || !hs_out_dir || (line2_sync && !line2_prev)) begin
				data_avail_pend <= 1'b0;
			end
			if (hs_active && hs_out_dir && wr_out) begin
				data_avail_pend <= 1'b1; // RQ18
			end
			if (rd_in || !hs_active || hs_out_dir) begin
				in_full <= 1'b0;
			end
			if (hs_active && !hs_out_dir && !in_full && !line2_sync && line2_prev) begin
				in_full  <= 1'b1; // RQ18
				in_latch <= upper_sync;
			end
		end
	end

	assign upper_port_data_avail_n = !data_avail_pend;
	assign upper_port_hs_ready     = !in_full;

	// Upper port pins per nibble: address, output or input
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			upper_address_port_out <= 8'h00;
			drive_enable_n         <= 8'h00;
			ctrl_port_line5        <= 1'b1;
		end else begin
			if (lo_mode == `EMBC_NIB_ADDR) begin
				if (start) begin
					upper_address_port_out[3:0] <= start_addr[11:8]; // RQ19
				end
				drive_enable_n[3:0] <= 4'h0;
			end else begin
				upper_address_port_out[3:0] <= out_data[3:0];
				drive_enable_n[3:0] <= {4{lo_mode != `EMBC_NIB_OUT}}; // RQ17
			end
			if (hi_mode == `EMBC_NIB_ADDR) begin
				if (start) begin
					upper_address_port_out[7:4] <= start_addr[15:12]; // RQ19
				end
				drive_enable_n[7:4] <= 4'h0;
			end else begin
				upper_address_port_out[7:4] <= out_data[7:4];
				drive_enable_n[7:4] <= {4{hi_mode != `EMBC_NIB_OUT}}; // RQ17
			end
			if (!hs_active) begin
				ctrl_port_line5 <= 1'b1;
			end else if (hs_out_dir) begin
				ctrl_port_line5 <= upper_port_data_avail_n; // RQ18
			end else begin
				ctrl_port_line5 <= upper_port_hs_ready; // RQ18
			end
		end
	end

	// Register reads, data one cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == `EMBC_REG_MODE) begin
				reg_rdata <= mode;
			end else if (reg_addr == `EMBC_REG_OUT) begin
				reg_rdata <= out_data;
			end else if (reg_addr == `EMBC_REG_IN) begin
				// Synced copy keeps a settled level for undriven inputs
				reg_rdata <= hs_active ? in_latch : upper_sync; // RQ22
			end else if (reg_addr == `EMBC_REG_STATUS) begin
				reg_rdata <= 8'h00;
				reg_rdata[`EMBC_ST_BUSY_BIT]   <= state != embc_pkg::EMBC_ST_IDLE;
				reg_rdata[`EMBC_ST_BOOT_BIT]   <= boot_pending;
				reg_rdata[`EMBC_ST_INFULL_BIT] <= in_full;
				reg_rdata[`EMBC_ST_DAV_BIT]    <= data_avail_pend;
				reg_rdata[`EMBC_ST_RST_BIT]    <= int_rst;
			end else begin
				reg_rdata <= 8'h00;
			end
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// Core status pins and system clock
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irq_cycle_flag <= 1'b0;
			instr_end_n    <= 1'b1;
			sys_clk_out    <= 1'b0;
		end else begin
			irq_cycle_flag <= irq_cycle_in; // RQ13
			instr_end_n    <= !instr_last_in; // RQ14
			sys_clk_out    <= !sys_clk_out; // RQ12
		end
	end
endmodule
`default_nettype wire

//--- tb/embc_monitor.sv
// Port checker for the external bus controller
`timescale 1ns/1ps
`default_nettype none
module embc_monitor (
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic       req_valid,
	input wire logic       req_ready,
	input wire logic       req_write,
	input wire logic [7:0] req_wdata,
	input wire logic       resp_valid,
	input wire logic       irq_cycle_in,
	input wire logic       instr_last_in,
	input wire logic       irq_cycle_flag,
	input wire logic       instr_end_n,
	input wire logic       sys_clk_out,
	input wire logic       mem_strobe_n,
	input wire logic       addr_latch_pulse_n,
	input wire logic       read_write,
	input wire logic       stall_n,
	input wire logic [7:0] muxed_bus_out,
	input wire logic       muxed_bus_oe_n,
	input wire logic       int_rst
);
	logic [7:0] hold_cnt;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Cycles spent in internal reset
	always_ff @(posedge ref_clk) begin
		if (!int_rst)
			hold_cnt <= 8'h00;
		else if (hold_cnt != 8'hFF)
			hold_cnt <= hold_cnt + 8'h01;
	end
	sequence s_taken; req_valid && req_ready; endsequence
	sequence s_stall_held; !stall_n [*4]; endsequence
	property p_strobe_end; resp_valid |-> $rose(mem_strobe_n); endproperty
	a_strobe_end: assert property (p_strobe_end) else $error("strobe not ended");
	property p_wdata;
		!read_write && $fell(mem_strobe_n)
			|-> !muxed_bus_oe_n && muxed_bus_out == $past(req_wdata, 3);
	endproperty
	a_wdata: assert property (p_wdata) else $error("write data not driven");
	property p_latch;
		!int_rst && !$past(int_rst) && $fell(addr_latch_pulse_n) |=> addr_latch_pulse_n;
	endproperty
	a_latch: assert property (p_latch) else $error("latch pulse too long");
	property p_dir; s_taken |=> read_write == !$past(req_write); endproperty
	a_dir: assert property (p_dir) else $error("wrong direction");
	property p_rst_cyc;
		int_rst && $past(int_rst) && $past(int_rst, 2)
			|-> !mem_strobe_n && addr_latch_pulse_n != $past(addr_latch_pulse_n);
	endproperty
	a_rst_cyc: assert property (p_rst_cyc) else $error("bad reset cycling");
	property p_hold; $fell(int_rst) |-> hold_cnt >= 8'h12; endproperty
	a_hold: assert property (p_hold) else $error("reset too short");
	property p_sysclk; $past(rst_n) |-> sys_clk_out != $past(sys_clk_out); endproperty
	a_sysclk: assert property (p_sysclk) else $error("system clock stuck");
	property p_irq; irq_cycle_in |=> irq_cycle_flag; endproperty
	a_irq: assert property (p_irq) else $error("interrupt flag low");
	property p_end; instr_last_in |=> !instr_end_n; endproperty
	a_end: assert property (p_end) else $error("instruction end high");
	property p_stall;
		s_stall_held ##0 (!mem_strobe_n && !int_rst) |=> !mem_strobe_n;
	endproperty
	a_stall: assert property (p_stall) else $error("stall ignored");
endmodule
bind embc_bus_ctrl embc_monitor u_embc_monitor (.ref_clk, .rst_n, .req_valid, .req_ready,
	.req_write, .req_wdata, .resp_valid, .irq_cycle_in, .instr_last_in, .irq_cycle_flag,
	.instr_end_n, .sys_clk_out, .mem_strobe_n, .addr_latch_pulse_n, .read_write, .stall_n,
	.muxed_bus_out, .muxed_bus_oe_n, .int_rst);
`default_nettype wire

//--- tb/embc_mem_model.sv
// External memory on the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module embc_mem_model (
	input  wire logic        ref_clk,
	input  wire logic        mem_strobe_n,
	input  wire logic        addr_latch_pulse_n,
	input  wire logic        read_write,
	input  wire logic [7:0]  muxed_bus_out,
	input  wire logic [7:0]  upper_address_port_out,
	input  wire logic [3:0]  stall_len,
	output logic      [7:0]  muxed_bus_in,
	output logic             stall_n,
	output logic      [15:0] last_addr,
	output logic      [7:0]  last_wdata
);
	logic       as_q = 1'b1;
	logic       ds_q = 1'b1;
	logic [4:0] st_cnt = 5'h00;
	logic [7:0] junk = 8'hA5;
	always @(posedge ref_clk) begin
		as_q <= addr_latch_pulse_n;
		ds_q <= mem_strobe_n;
		junk <= ~junk;
		st_cnt <= mem_strobe_n ? 5'h00 : (st_cnt == 5'h1F ? st_cnt : st_cnt + 5'h01);
		if (!as_q && addr_latch_pulse_n)
			last_addr <= {upper_address_port_out, muxed_bus_out};
		if (ds_q && !mem_strobe_n && !read_write)
			last_wdata <= muxed_bus_out;
	end
	// Data only under a read strobe, else a changing pattern
	assign muxed_bus_in = (!mem_strobe_n && read_write) ?
		(last_addr[7:0] ^ last_addr[15:8] ^ 8'h5A) : junk;
	// Stall from strobe fall for stall_len cycles, pulled high otherwise
	assign stall_n = mem_strobe_n || ({1'b0, stall_len} <= st_cnt);
endmodule
`default_nettype wire

//--- tb/embc_bus_ctrl_test.sv
// Self-checking bench for the external bus controller
`timescale 1ns/1ps
`default_nettype none
`include "embc_map.svh"
module embc_bus_ctrl_test;
	logic        ref_clk, rst_n, ext_reset_n, reg_wr, reg_rd, req_valid, req_write, req_ready;
	logic        irq_cycle_in, instr_last_in, ctrl_port_line2, ctrl_port_line5, resp_valid;
	logic        resp_boot, irq_cycle_flag, instr_end_n, sys_clk_out, mem_strobe_n, int_rst;
	logic        addr_latch_pulse_n, read_write, stall_n, muxed_bus_oe_n, seen;
	logic [3:0]  reg_addr, stall_len;
	logic [7:0]  reg_wdata, reg_rdata, up_in, req_wdata, rd, resp_rdata, last_wdata;
	logic [7:0]  muxed_bus_in, muxed_bus_out, upper_address_port_out, drive_enable_n;
	logic [15:0] req_addr, last_addr;
	int          n_mismatch, n_checks, lat0, lat1, n;
	embc_bus_ctrl u_embc_bus_ctrl (.ref_clk, .rst_n, .ext_reset_n, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .req_valid, .req_ready, .req_write, .req_addr,
		.req_wdata, .resp_valid, .resp_rdata, .resp_boot, .irq_cycle_in, .instr_last_in,
		.irq_cycle_flag, .instr_end_n, .sys_clk_out, .mem_strobe_n, .addr_latch_pulse_n,
		.read_write, .stall_n, .muxed_bus_in, .muxed_bus_out, .muxed_bus_oe_n,
		.upper_address_port_in(up_in), .upper_address_port_out, .drive_enable_n,
		.ctrl_port_line2, .ctrl_port_line5, .int_rst);
	embc_mem_model u_embc_mem_model (.ref_clk, .mem_strobe_n, .addr_latch_pulse_n,
		.read_write, .muxed_bus_out, .upper_address_port_out, .stall_len, .muxed_bus_in,
		.stall_n, .last_addr, .last_wdata);
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic reg_read(input logic [3:0] a);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		rd = reg_rdata;
		@(posedge ref_clk);
	endtask
	task automatic wait_resp(output int lat);
		lat = 0;
		do begin
			@(negedge ref_clk);
			lat++;
		end while (resp_valid !== 1'b1 && lat < 300);
		chk(16'(lat < 300), 16'h0001);
	endtask
	// One core bus cycle; ea is the address the memory should latch
	task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d,
		input logic [15:0] ea, output int lat);
		n = 0;
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		@(negedge ref_clk);
		while (req_ready !== 1'b1 && n < 300) begin
			@(negedge ref_clk);
			n++;
		end
		@(posedge ref_clk);
		req_valid <= 1'b0;
		wait_resp(lat);
		chk(last_addr, ea);
		if (w)
			chk(16'(last_wdata), 16'(d));
		else
			chk(16'(resp_rdata), 16'(ea[7:0] ^ ea[15:8] ^ 8'h5A));
		@(posedge ref_clk);
	endtask
	task automatic t_boot;
		wait_resp(lat0);
		chk(16'(resp_boot), 16'h0001);
		chk(last_addr, `EMBC_RESET_VECTOR);
		chk(16'(resp_rdata), 16'h0056);
		@(posedge ref_clk);
		reg_read(`EMBC_REG_MODE);
		chk(16'(rd), 16'(`EMBC_MODE_RESET));
		reg_read(4'hF);
		chk(16'(rd), 16'h0000);
		$display("t_boot done");
	endtask
	task automatic t_rw;
		bus(1'b1, 16'h1234, 8'hC3, 16'h1234, lat1);
		bus(1'b0, 16'hABCD, 8'h00, 16'hABCD, lat1);
		reg_write(`EMBC_REG_MODE, 8'h0A);
		bus(1'b0, 16'h4321, 8'h00, 16'h4321, lat0);
		chk(16'(lat1 - lat0), 16'(`EMBC_EXT_STROBE_CYC));
		stall_len <= 4'h5;
		bus(1'b0, 16'h0F0F, 8'h00, 16'h0F0F, lat1);
		stall_len <= 4'h0;
		chk(16'(lat1 > lat0), 16'h0001);
		$display("t_rw done");
	endtask
	task automatic t_nibble;
		up_in <= 8'h9C;
		reg_write(`EMBC_REG_MODE, 8'h06);
		reg_write(`EMBC_REG_OUT, 8'h5A);
		@(negedge ref_clk);
		chk(16'(upper_address_port_out[7:4]), 16'h0005);
		chk(16'(drive_enable_n), 16'h0000);
		@(posedge ref_clk);
		bus(1'b0, 16'hF7E1, 8'h00, 16'h57E1, lat1);
		reg_write(`EMBC_REG_MODE, 8'h02);
		@(negedge ref_clk);
		chk(16'(drive_enable_n[7:4]), 16'h000F);
		@(posedge ref_clk);
		reg_read(`EMBC_REG_IN);
		chk(16'(rd[7:4]), 16'h0009);
		$display("t_nibble done");
	endtask
	task automatic t_hs;
		reg_write(`EMBC_REG_MODE, 8'h25);
		@(negedge ref_clk);
		chk(16'(ctrl_port_line5), 16'h0001);
		@(posedge ref_clk);
		reg_write(`EMBC_REG_OUT, 8'h3C);
		n = 0;
		while (ctrl_port_line5 !== 1'b0 && n < 8) begin
			@(negedge ref_clk);
			n++;
		end
		chk(16'(n < 8), 16'h0001);
		@(posedge ref_clk);
		ctrl_port_line2 <= 1'b1;
		n = 0;
		while (ctrl_port_line5 !== 1'b1 && n < 8) begin
			@(negedge ref_clk);
			n++;
		end
		chk(16'(n < 8), 16'h0001);
		@(posedge ref_clk);
		reg_write(`EMBC_REG_MODE, 8'h20);
		@(negedge ref_clk);
		chk(16'(ctrl_port_line5), 16'h0001);
		@(posedge ref_clk);
		ctrl_port_line2 <= 1'b0;
		repeat (6) @(negedge ref_clk);
		chk(16'(ctrl_port_line5), 16'h0000);
		@(posedge ref_clk);
		reg_read(`EMBC_REG_IN);
		chk(16'(rd), 16'h009C);
		@(negedge ref_clk);
		chk(16'(ctrl_port_line5), 16'h0001);
		@(posedge ref_clk);
		$display("t_hs done");
	endtask
	task automatic t_core;
		irq_cycle_in <= 1'b1;
		instr_last_in <= 1'b1;
		@(posedge ref_clk);
		@(negedge ref_clk);
		rd[0] = sys_clk_out;
		chk(16'(irq_cycle_flag), 16'h0001);
		chk(16'(instr_end_n), 16'h0000);
		@(negedge ref_clk);
		chk(16'(sys_clk_out), 16'(!rd[0]));
		@(posedge ref_clk);
		irq_cycle_in <= 1'b0;
		instr_last_in <= 1'b0;
		$display("t_core done");
	endtask
	task automatic t_ext;
		seen = 1'b0;
		ext_reset_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		ext_reset_n <= 1'b1;
		repeat (20) begin
			@(negedge ref_clk);
			seen |= int_rst;
		end
		chk(16'(seen), 16'h0000);
		@(posedge ref_clk);
		ext_reset_n <= 1'b0;
		repeat (40) @(negedge ref_clk);
		chk(16'(int_rst), 16'h0001);
		@(posedge ref_clk);
		ext_reset_n <= 1'b1;
		wait_resp(lat0);
		chk(16'(resp_boot), 16'h0001);
		chk(last_addr, `EMBC_RESET_VECTOR);
		@(posedge ref_clk);
		reg_read(`EMBC_REG_MODE);
		chk(16'(rd), 16'(`EMBC_MODE_RESET));
		$display("t_ext done");
	endtask
	task automatic results;
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		results();
	end
	initial begin
		{rst_n, reg_wr, reg_rd, req_valid, req_write, irq_cycle_in, instr_last_in} = '0;
		{ctrl_port_line2, reg_addr, stall_len, reg_wdata, up_in, req_wdata, req_addr} = '0;
		ext_reset_n = 1'b1;
		n_mismatch = 0;
		n_checks = 0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_boot();
		t_rw();
		t_nibble();
		t_hs();
		t_core();
		t_ext();
		results();
	end
endmodule
`default_nettype wire
